// ### hw/sbsp_port.sv
// Synchronous flow-through burst SRAM port with sleep control
// Summary of operation
// - Select only when all three selects active
// - Full write by global or all lanes
// - Writes ignored in cpu strobe start cycle
// - Inactive step holds burst address
// - Controller strobe extends write burst
// - Data lines float after write until read
// - Data lines float after leaving sleep
module sbsp_port
	import sbsp_pkg::*;
#(
	parameter int ADDR_W = sbsp_pkg::SBSP_ADDR_W,       // Word address width
	parameter int LANES  = sbsp_pkg::SBSP_LANES         // Byte lanes
) (
	input  wire logic                          core_clk,        // Clock
	input  wire logic                          rst,             // Synchronous reset, high
	input  wire sbsp_pkg::sbsp_ctl_t           ctl,             // Selects and write qualifiers
	input  wire sbsp_pkg::sbsp_strb_t          strb,            // Address strobes and step
	input  wire logic [ADDR_W-1:0]             addr,            // Word address
	input  wire logic [LANES*8-1:0]            data_in,         // Data lines, input side
	output logic      [LANES*8-1:0]            data_out,        // Data lines, output side
	output logic                               data_oe_n,       // Data lines enable, low drives
	input  wire logic                          output_drive_n,  // Output drive enable, low active
	input  wire logic                          sleep_request    // Low-power sleep request
);
	import sbsp_pkg::*;

	localparam int DW = LANES * 8;

	// ****************************************************
	// State
	// ****************************************************
	logic [DW-1:0]     mem [0:(1<<ADDR_W)-1];
	logic [ADDR_W-1:0] base_addr;
	logic [1:0]        burst_ofs;
	sbsp_op_t          op;
	logic              drive_en;     // Read launched and not since ended
	logic              sleeping;

	logic              sel;
	logic              start_p;
	logic              start_c;
	logic              start;
	logic              wr_req;
	logic [LANES-1:0]  lane_we;
	logic [1:0]        cur_low;      // Low address bits of the current beat
	logic [1:0]        step_low;     // Low address bits one step on
	logic [ADDR_W-1:0] cur_addr;
	logic [ADDR_W-1:0] step_addr;
	logic [ADDR_W-1:0] next_addr;
	logic [LANES-1:0]  next_we;

	// ****************************************************
	// Decode
	// ****************************************************
	// three-way select
	assign sel = !ctl.primary_chip_select_n && ctl.expansion_select_high && !ctl.expansion_select_low_n;
	// Cpu strobe wins over controller strobe when both are low
	assign start_p = !strb.cpu_address_strobe_n && !sleeping;
	assign start_c = strb.cpu_address_strobe_n && !strb.controller_address_strobe_n && !sleeping;
	assign start   = start_p || start_c;
	// full write via global, otherwise gated lanes
	always_comb begin
		if (!ctl.global_write_n)
			lane_we = '1;
		else if (!ctl.byte_write_gate_n)
			lane_we = ~ctl.byte_write_lanes_n;
		else
			lane_we = '0;
	end
	assign wr_req   = |lane_we;
	// The counter steps only the low two bits, so a burst stays inside its
	// aligned group of four and never runs into the neighbouring words
	assign cur_low   = base_addr[1:0] + burst_ofs;
	assign step_low  = cur_low + SBSP_BURST_INC;
	assign cur_addr  = {base_addr[ADDR_W-1:2], cur_low};
	assign step_addr = {base_addr[ADDR_W-1:2], step_low};

	// Address and write enables for this edge
	always_comb begin
		next_addr = cur_addr;
		next_we   = '0;
		if (start && sel) begin
			next_addr = addr;
			// qualifiers ignored on the cpu strobe cycle
			if (start_c)
				next_we = lane_we;
		end else if (!start && op != SBSP_IDLE) begin
			// step low moves to the next beat, high holds the address
			if (!strb.burst_step_n)
				next_addr = step_addr;
			// Writes land on the address of the coming beat, in read or write bursts
			next_we = lane_we;
		end
	end

	// ****************************************************
	// Burst address and operation
	// ****************************************************
	// Only the low two offset bits wrap, as a 2-bit counter does
	always_ff @(posedge core_clk) begin
		if (rst) begin
			base_addr <= '0;
			burst_ofs <= SBSP_BURST_RST;
			op        <= SBSP_IDLE;
		end else if (sleeping) begin
			op <= SBSP_IDLE;
		end else if (start) begin
			if (sel) begin
				base_addr <= addr;
				burst_ofs <= SBSP_BURST_RST;
				// controller strobe with writes keeps write burst going
				if (start_c && wr_req)
					op <= SBSP_WRITE;
				else if (start_p)
					op <= (op == SBSP_WRITE && wr_req) ? SBSP_WRITE : SBSP_READ;
				else
					op <= SBSP_READ;
			end else begin
				op <= SBSP_IDLE;
			end
		end else if (op != SBSP_IDLE) begin
			// A write qualifier during a cpu-started burst turns it into a write
			if (wr_req)
				op <= SBSP_WRITE;
			if (!strb.burst_step_n)
				burst_ofs <= burst_ofs + SBSP_BURST_INC;
		end
	end

	// Array write with per-lane strobes at the address of the coming beat
	// A controller-started write thus lands on the strobe address itself,
	// and a continued write on the stepped or held burst address
	always_ff @(posedge core_clk) begin
		if (!rst && !sleeping) begin
			for (int i = 0; i < LANES; i++) begin
				if (next_we[i])
					mem[next_addr][i*8 +: 8] <= data_in[i*8 +: 8];
			end
		end
	end

	// ****************************************************
	// Sleep and output drive
	// ****************************************************
	// Sleep is honoured as given; the master is relied on to deselect first
	always_ff @(posedge core_clk) begin
		if (rst)
			sleeping <= 1'b0;
		else
			sleeping <= sleep_request;
	end

	// drive stays off after a write until a read is launched
	// sleep clears drive so the lines float on exit
	always_ff @(posedge core_clk) begin
		if (rst || sleeping)
			drive_en <= 1'b0;
		else if (start)
			drive_en <= sel && !(start_c && wr_req);
		else if (wr_req && op != SBSP_IDLE)
			drive_en <= 1'b0;
	end

	// flow-through read word registered out each edge
	always_ff @(posedge core_clk) begin
		if (rst)
			data_out <= '0;
		else
			data_out <= mem[next_addr];
	end

	assign data_oe_n = !(drive_en && op == SBSP_READ && !output_drive_n && !sleeping);

	// ****************************************************
	// Checks
	// ****************************************************
	// Checked against the pins where possible, so a broken decode cannot hide
	a_sel_decode: assert property (@(posedge core_clk) disable iff (rst)
		(start && (ctl.primary_chip_select_n || !ctl.expansion_select_high || ctl.expansion_select_low_n))
		|=> op == SBSP_IDLE)
		else $error("deselected start opened an access");
	a_full_write: assert property (@(posedge core_clk) disable iff (rst)
		!ctl.global_write_n |-> lane_we == '1)
		else $error("global write did not enable all lanes");
	a_cpu_start_nowr: assert property (@(posedge core_clk) disable iff (rst)
		(start_p && sel) |-> next_we == '0)
		else $error("write taken on cpu strobe cycle");
	a_step_hold: assert property (@(posedge core_clk) disable iff (rst)
		(!start && !sleeping && strb.burst_step_n && op != SBSP_IDLE) |=> $stable(burst_ofs))
		else $error("burst advanced with step inactive");
	a_step_move: assert property (@(posedge core_clk) disable iff (rst)
		(!start && !sleeping && !strb.burst_step_n && op != SBSP_IDLE)
		|=> burst_ofs == $past(burst_ofs) + SBSP_BURST_INC)
		else $error("burst did not advance with step active");
	a_ctrl_extend: assert property (@(posedge core_clk) disable iff (rst)
		(start_c && sel && !ctl.global_write_n) |=> op == SBSP_WRITE)
		else $error("controller strobe did not extend write");
	a_float_write: assert property (@(posedge core_clk) disable iff (rst)
		(op == SBSP_WRITE) |-> data_oe_n)
		else $error("data driven during write");
	a_float_after: assert property (@(posedge core_clk) disable iff (rst)
		(!start && wr_req && op != SBSP_IDLE) |=> data_oe_n)
		else $error("data driven after a write beat");
	a_sleep_float: assert property (@(posedge core_clk) disable iff (rst)
		$fell(sleeping) |-> data_oe_n)
		else $error("data driven on sleep exit");
	a_sleep_idle: assert property (@(posedge core_clk) disable iff (rst)
		sleeping |=> op == SBSP_IDLE)
		else $error("access kept open while sleeping");
	a_drive_gate: assert property (@(posedge core_clk) disable iff (rst)
		output_drive_n |-> data_oe_n)
		else $error("data driven with output drive high");
	c_read: cover property (@(posedge core_clk) disable iff (rst) start_p && sel ##1 !data_oe_n);
	c_ext_write: cover property (@(posedge core_clk) disable iff (rst) op == SBSP_WRITE ##1 start_c && sel);
	c_sleep: cover property (@(posedge core_clk) disable iff (rst) $fell(sleeping));
	c_step_hold: cover property (@(posedge core_clk) disable iff (rst) op == SBSP_READ && strb.burst_step_n);
	c_cpu_write: cover property (@(posedge core_clk) disable iff (rst) start_p && sel ##1 !start && wr_req);

endmodule // sbsp_port

// ### hw/sbsp_pkg.sv
// Package for the synchronous burst SRAM port: widths, burst constants, carrier types
package sbsp_pkg;

	// ****************************************************
	// Sizes and constants
	// ****************************************************
	localparam int         SBSP_ADDR_W   = 10;      // Word address width of the array
	localparam int         SBSP_LANES    = 4;       // Byte lanes per word
	localparam int         SBSP_DATA_W   = 32;      // Word width
	localparam logic [1:0] SBSP_BURST_RST = 2'h0;   // Burst offset after reset
	localparam logic [1:0] SBSP_BURST_INC = 2'h1;   // Burst offset step

	// Operation kinds held for the current access
	typedef enum logic [2:0] {
		SBSP_IDLE  = 3'b001,
		SBSP_READ  = 3'b010,
		SBSP_WRITE = 3'b100
	} sbsp_op_t;

	// Select and write qualifier pins grouped together
	typedef struct packed {
		logic                  primary_chip_select_n;
		logic                  expansion_select_high;
		logic                  expansion_select_low_n;
		logic                  global_write_n;
		logic                  byte_write_gate_n;
		logic [SBSP_LANES-1:0] byte_write_lanes_n;
	} sbsp_ctl_t;

	// Burst control strobes
	typedef struct packed {
		logic cpu_address_strobe_n;
		logic controller_address_strobe_n;
		logic burst_step_n;
	} sbsp_strb_t;

endpackage // sbsp_pkg

// ### test/sbsp_master_model.sv
// Bus master model that drives the burst SRAM port and notes expected reads
module sbsp_master_model
	import sbsp_pkg::*;
(
	input  wire logic            core_clk,        // Clock
	output sbsp_pkg::sbsp_ctl_t  ctl,             // Selects and write qualifiers
	output sbsp_pkg::sbsp_strb_t strb,            // Strobes and step
	output logic [9:0]           addr,            // Word address
	output logic [31:0]          data_in,         // Write data
	output logic                 output_drive_n,  // Output drive, low active
	output logic                 sleep_request    // Sleep request
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************
	// Reference copy and expected reads
	// ****************************************************
	logic [31:0] mem [int];
	logic [31:0] exp_q [$];
	int          seed = 32'h59dff6f7;

	// Linear wrap inside the aligned group of four
	function automatic logic [9:0] wrap(input logic [9:0] a, input int i);
		return {a[9:2], a[1:0] + 2'(i)};
	endfunction
	function automatic logic [31:0] rnd();
		return $random(seed);
	endfunction

	// Deselected and idle from time zero
	initial begin
		ctl = 9'h1bf;
		strb = 3'h7;
		addr = 10'h0;
		data_in = 32'h0;
		output_drive_n = 1'b1;
		sleep_request = 1'b0;
	end

	// One cycle, changed just after the edge and held a full period
	task automatic beat(input logic [8:0] c, input logic [2:0] s, input logic [9:0] a, input logic [31:0] d,
		input logic odn);
		@(posedge core_clk);
		#1;
		ctl = c;
		strb = s;
		addr = a;
		data_in = d;
		output_drive_n = odn;
	endtask
	// Released data lines toggle so a stale value is never mistaken for data
	task automatic idle();
		beat(9'h1bf, 3'h7, 10'(rnd()), rnd(), 1'b1);
	endtask
	// full width write, global or all lanes
	// controller strobe opens the write burst
	task automatic write(input logic [8:0] wm, input logic [9:0] a);
		logic [31:0] d;
		for (int i = 0; i < 4; i++) begin
			d = rnd();
			beat(wm, (i == 0) ? 3'b101 : 3'b110, a, d, 1'b1);
			mem[wrap(a, i)] = d;
		end
	endtask
	// Read burst; a set bit of hold keeps the step input high for that beat
	task automatic read(input logic [9:0] a, input logic [3:0] hold);
		int off;
		off = 0;
		beat(9'h0bf, 3'b011, a, rnd(), 1'b1);
		for (int i = 0; i < 4; i++) begin
			beat(9'h0bf, {2'b11, hold[i]}, a, rnd(), 1'b0);
			exp_q.push_back(mem[wrap(a, off)]);
			off += hold[i] ? 0 : 1;
		end
	endtask
	// write on the cpu strobe cycle is ignored; the stepped next beat lands
	task automatic cpu_write(input logic [9:0] a);
		logic [31:0] d;
		d = rnd();
		beat(9'h09f, 3'b011, a, rnd(), 1'b1);
		beat(9'h09f, 3'b110, a, d, 1'b1);
		mem[wrap(a, 1)] = d;
	endtask
	task automatic nap();
		idle();
		sleep_request = 1'b1;
		repeat (3) idle();
		sleep_request = 1'b0;
		idle();
	endtask
endmodule // sbsp_master_model

// ### test/tb.sv
// Self-checking bench for the burst SRAM port
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 core_clk = 1'b0;
	logic                 rst = 1'b1;
	sbsp_pkg::sbsp_ctl_t  ctl;
	sbsp_pkg::sbsp_strb_t strb;
	logic [9:0]           addr;
	logic [31:0]          data_in;
	logic [31:0]          data_out;
	logic                 data_oe_n;
	logic                 output_drive_n;
	logic                 sleep_request;
	logic [8:0]           dsel [3] = '{9'h1bf, 9'h03f, 9'h0ff};
	int                   fails = 0;
	int                   samples_checked = 0;

	initial begin
		forever #5 core_clk = ~core_clk;
	end

	sbsp_master_model u_m (.core_clk(core_clk), .ctl(ctl), .strb(strb), .addr(addr), .data_in(data_in),
		.output_drive_n(output_drive_n), .sleep_request(sleep_request));
	sbsp_port DUT (.core_clk(core_clk), .rst(rst), .ctl(ctl), .strb(strb), .addr(addr), .data_in(data_in),
		.data_out(data_out), .data_oe_n(data_oe_n), .output_drive_n(output_drive_n), .sleep_request(sleep_request));

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Selected, no strobe, drive enabled: data lines must stay released
	task automatic floating();
		u_m.beat(9'h0bf, 3'h7, 10'h0, u_m.rnd(), 1'b0);
		@(negedge core_clk);
		check({31'h0, data_oe_n}, 32'h1);
	endtask

	// Every driven word is matched against the oldest noted read
	always @(negedge core_clk) begin
		if (!rst && data_oe_n === 1'b0) begin
			if (u_m.exp_q.size() == 0) begin
				check({31'h0, data_oe_n}, 32'h1);
			end else begin
				check(data_out, u_m.exp_q.pop_front());
			end
		end
	end

	initial begin
		repeat (2) @(posedge core_clk);
		#1;
		rst = 1'b0;
		u_m.write(9'h09f, 10'h3a2);
		floating();
		u_m.read(10'h3a2, 4'b0000);
		u_m.write(9'h0a0, 10'h105);
		u_m.read(10'h105, 4'b0101);
		u_m.cpu_write(10'h105);
		u_m.read(10'h105, 4'b0000);
		u_m.write(9'h09f, 10'h200);
		foreach (dsel[i]) begin
			u_m.beat(dsel[i], 3'b011, 10'h200, u_m.rnd(), 1'b1);
			floating();
		end
		u_m.read(10'h200, 4'b0000);
		u_m.write(9'h09f, 10'h0c4);
		u_m.write(9'h0a0, 10'h0c9);
		u_m.read(10'h0c4, 4'b0000);
		u_m.read(10'h0c9, 4'b0000);
		u_m.nap();
		floating();
		u_m.read(10'h3a0, 4'b1000);
		// Release the lines and let the last noted word be compared first
		u_m.idle();
		@(negedge core_clk);
		check(32'(u_m.exp_q.size()), 32'h0);
		test_done();
	end

	// Watchdog: the whole sequence needs well under a hundred cycles
	initial begin
		#3000;
		fails++;
		test_done();
	end
endmodule // tb
